/* File: shared/sse_defs.vh */
// Purpose: constants for the subtract, swap and skip execution block
// Assumes: 8-bit data path, one instruction issued per cycle on op_valid
// Notes: operation codes are local to this block
// What this block does
// - Memory subtract writes working minus byte back to memory, working kept.
// - Immediate subtract puts working minus immediate into the working register.
// - Borrow-inverse flag is 0 on a negative difference, else 1.
// - Subtractions change exactly six flags, no other flag.
// - In-place nibble exchange swaps byte halves in memory, flags untouched.
// - Exchange to working loads swapped memory nibbles into working register.
// - Exchange to working leaves the memory byte unchanged.
// - Skip-on-null skips the next instruction when the byte is zero.
// - Copy-and-skip always loads working, skips when the byte is zero.
// - Bit-skip tests the indexed bit and skips when it is zero.
// - A taken skip inserts one dummy cycle, two cycles in all.
// - A non-zero test lets the following instruction run normally.
`ifndef SSE_DEFS_VH
`define SSE_DEFS_VH
`define SSE_OP_NONE 3'h0
`define SSE_OP_SUB_MEM 3'h1
`define SSE_OP_SUB_IMM 3'h2
`define SSE_OP_SWAP_MEM 3'h3
`define SSE_OP_SWAP_WORK 3'h4
`define SSE_OP_SKIP_BYTE 3'h5
`define SSE_OP_COPY_SKIP 3'h6
`define SSE_OP_SKIP_BIT 3'h7
`define SSE_WORK_RESET 8'h00
`define SSE_FLAG_RESET 6'h00
`define SSE_F_RANGE 5
`define SSE_F_NULL 4
`define SSE_F_NIBBLE 3
`define SSE_F_BORROWN 2
`define SSE_F_SBORROW 1
`define SSE_F_CZERO 0
`endif

/* File: src/sse_subtractor.v */
// Purpose: 8-bit subtract with status flag results
// Assumes: operands are unsigned bytes, a is minuend
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none
module sse_subtractor #(
    parameter WIDTH = 8
) (
    // Operands
    input wire [WIDTH-1:0] a,
    input wire [WIDTH-1:0] b,
    // Results
    output wire [WIDTH-1:0] diff,
    output wire borrow_n,
    output wire nibble_carry,
    output wire overflow,
    output wire is_null
);
    wire [WIDTH:0] full;
    wire [4:0] low;

    // Extra bit catches the borrow out of the top
    assign full = {1'b0, a} - {1'b0, b};
    assign low = {1'b0, a[3:0]} - {1'b0, b[3:0]};
    assign diff = full[WIDTH-1:0];
    assign borrow_n = ~full[WIDTH];
    assign nibble_carry = ~low[4];
    // Signs differ and result sign departs from the minuend
    assign overflow = (a[WIDTH-1] ^ b[WIDTH-1]) &
                      (a[WIDTH-1] ^ full[WIDTH-1]);
    assign is_null = (full[WIDTH-1:0] == {WIDTH{1'b0}});
endmodule // sse_subtractor
`default_nettype wire

/* File: src/sse_skip_test.v */
// Purpose: zero test for the skip instructions
// Assumes: bit index valid only for the bit form
// Notes: combinational
`timescale 1ns/1ps
`default_nettype none
module sse_skip_test (
    // Inputs
    input wire [7:0] data,
    input wire [2:0] bit_index,
    input wire bit_mode,
    // Result
    output wire is_zero
);
    // Bit form looks at one bit, byte form at all eight
    assign is_zero = bit_mode ? ~data[bit_index] : (data == 8'h00);
endmodule // sse_skip_test
`default_nettype wire

/* File: src/sse_exec.v */
// Purpose: execute subtract, nibble swap and skip-on-zero instructions
// Assumes: fetch holds off issue while busy; mem_rdata valid with op_valid
// Notes: chained zero copies the result zero test on every subtract
`timescale 1ns/1ps
`default_nettype none
`include "sse_defs.vh"
module sse_exec (
    // Clock and reset
    input wire clk,
    input wire resetn,
    // Instruction issue
    input wire op_valid,
    input wire [2:0] op_code,
    input wire [7:0] op_imm,
    input wire [2:0] op_bit,
    input wire [7:0] op_addr,
    // Data memory read value for op_addr
    input wire [7:0] mem_rdata,
    // Data memory write
    output reg mem_we,
    output reg [7:0] mem_addr,
    output reg [7:0] mem_wdata,
    // Core state
    output reg [7:0] working_register,
    output reg signed_range_flag,
    output reg result_null_flag,
    output reg nibble_carry_flag,
    output reg borrow_inverse_flag,
    output reg signed_borrow_flag,
    output reg chained_zero_flag,
    // Sequencing
    output reg skip_next,
    output reg busy
);
    localparam ST_RUN = 1'b0;
    localparam ST_DUMMY = 1'b1;

    reg state;
    reg next_state;
    wire [7:0] sub_b;
    wire [7:0] diff;
    wire borrow_n;
    wire nib_c;
    wire ovf;
    wire is_null;
    wire test_zero;
    wire is_sub;
    wire is_skip;
    wire [7:0] swapped;

    // Memory subtract takes the byte, immediate subtract the operand
    assign sub_b = (op_code == `SSE_OP_SUB_IMM) ? op_imm : mem_rdata;
    assign is_sub = (op_code == `SSE_OP_SUB_MEM) ||
                    (op_code == `SSE_OP_SUB_IMM);
    assign is_skip = (op_code == `SSE_OP_SKIP_BYTE) ||
                     (op_code == `SSE_OP_COPY_SKIP) ||
                     (op_code == `SSE_OP_SKIP_BIT);
    assign swapped = {mem_rdata[3:0], mem_rdata[7:4]};

    sse_subtractor #(
        .WIDTH(8)
    ) u_sub (
        .a(working_register),
        .b(sub_b),
        .diff(diff),
        .borrow_n(borrow_n),
        .nibble_carry(nib_c),
        .overflow(ovf),
        .is_null(is_null)
    );

    sse_skip_test u_skip (
        .data(mem_rdata),
        .bit_index(op_bit),
        .bit_mode(op_code == `SSE_OP_SKIP_BIT),
        .is_zero(test_zero)
    );

    // Dummy cycle follows a taken skip; fetch discards in that slot
    always @* begin
        next_state = ST_RUN;
        case (state)
            ST_RUN: begin
                if (op_valid && is_skip && test_zero) begin
                    next_state = ST_DUMMY;
                end
            end
            ST_DUMMY: begin
                next_state = ST_RUN;
            end
            default: begin
                next_state = ST_RUN;
            end
        endcase
    end

    // Execute one instruction; issues during the dummy cycle are ignored
    always @(posedge clk) begin
        if (!resetn) begin
            state <= ST_RUN;
            mem_we <= 1'b0;
            mem_addr <= 8'h00;
            mem_wdata <= 8'h00;
            working_register <= `SSE_WORK_RESET;
            signed_range_flag <= 1'b0;
            result_null_flag <= 1'b0;
            nibble_carry_flag <= 1'b0;
            borrow_inverse_flag <= 1'b0;
            signed_borrow_flag <= 1'b0;
            chained_zero_flag <= 1'b0;
            skip_next <= 1'b0;
            busy <= 1'b0;
        end else begin
            state <= next_state;
            mem_we <= 1'b0;
            skip_next <= 1'b0;
            busy <= (next_state == ST_DUMMY);
            if (op_valid && state == ST_RUN) begin
                mem_addr <= op_addr;
                if (is_sub) begin
                    // Only these six flags move; all others hold
                    signed_range_flag <= ovf;
                    result_null_flag <= is_null;
                    nibble_carry_flag <= nib_c;
                    borrow_inverse_flag <= borrow_n;
                    signed_borrow_flag <= ~borrow_n;
                    chained_zero_flag <= is_null;
                end
                case (op_code)
                    `SSE_OP_SUB_MEM: begin
                        // Working register kept as is
                        mem_we <= 1'b1;
                        mem_wdata <= diff;
                    end
                    `SSE_OP_SUB_IMM: begin
                        working_register <= diff;
                    end
                    `SSE_OP_SWAP_MEM: begin
                        mem_we <= 1'b1;
                        mem_wdata <= swapped;
                    end
                    `SSE_OP_SWAP_WORK: begin
                        // No memory write, source byte survives
                        working_register <= swapped;
                    end
                    `SSE_OP_COPY_SKIP: begin
                        working_register <= mem_rdata;
                        skip_next <= test_zero;
                    end
                    `SSE_OP_SKIP_BYTE: begin
                        skip_next <= test_zero;
                    end
                    `SSE_OP_SKIP_BIT: begin
                        // Non-zero bit leaves skip low
                        skip_next <= test_zero;
                    end
                    default: begin
                        mem_we <= 1'b0;
                    end
                endcase
            end
        end
    end
endmodule // sse_exec
`default_nettype wire

/* File: tb/sse_exec_props.sv */
// Purpose: port checker for sse_exec
// Assumes: results show one cycle after the issue edge
// Notes: bound to every sse_exec instance
`timescale 1ns/1ps
`default_nettype none
module sse_exec_props (
    // Issue side
    input wire clk, resetn, op_valid,
    input wire [2:0] op_code, op_bit,
    input wire [7:0] op_imm, op_addr, mem_rdata,
    // Results
    input wire mem_we, busy, skip_next,
    input wire [7:0] mem_addr, mem_wdata, working_register,
    input wire signed_range_flag, result_null_flag, nibble_carry_flag,
    input wire borrow_inverse_flag, signed_borrow_flag, chained_zero_flag
);
    // Accepted issue and the tested bit
    wire take = op_valid && !busy;
    wire sel_bit = mem_rdata[op_bit];
    wire [5:0] flags = {signed_range_flag, result_null_flag,
        nibble_carry_flag, borrow_inverse_flag, signed_borrow_flag,
        chained_zero_flag};
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // Taken skip: pulse with busy, then one dummy cycle only
    sequence dummy_cycle;
        skip_next && busy ##1 !busy && !skip_next;
    endsequence
    AST_MINUS_TO_MEMORY: assert property (take && op_code == 3'h1 |=> mem_we
        && mem_wdata == $past(working_register) - $past(mem_rdata)
        && mem_addr == $past(op_addr) && $stable(working_register))
        else $error("memory subtract wrong");
    AST_SUBI: assert property (take && op_code == 3'h2 |=>
        working_register == $past(working_register) - $past(op_imm)
        && result_null_flag == (working_register == 8'h00))
        else $error("immediate subtract wrong");
    AST_BORROW: assert property (take && op_code == 3'h2 |=>
        borrow_inverse_flag == ($past(working_register) >= $past(op_imm)))
        else $error("borrow flag wrong");
    AST_SUBFLAGS: assert property (take && op_code == 3'h2 |=>
        signed_range_flag == (($past(working_register[7]) != $past(op_imm[7]))
        && (working_register[7] != $past(working_register[7])))
        && signed_borrow_flag == !borrow_inverse_flag
        && chained_zero_flag == result_null_flag)
        else $error("subtract flags wrong");
    AST_KEEP: assert property (take && op_code >= 3'h3 |=>
        $stable(flags)) else $error("flags changed");
    AST_SWAPM: assert property (take && op_code == 3'h3 |=> mem_we
        && mem_wdata == {$past(mem_rdata[3:0]), $past(mem_rdata[7:4])})
        else $error("swap in place wrong");
    AST_SWAPW: assert property (take && op_code == 3'h4 |=> !mem_we
        && working_register == {$past(mem_rdata[3:0]), $past(mem_rdata[7:4])})
        else $error("swap to working wrong");
    AST_COPY: assert property (take && op_code == 3'h6 |=>
        working_register == $past(mem_rdata)
        && skip_next == ($past(mem_rdata) == 8'h00))
        else $error("copy and skip wrong");
    AST_BIT: assert property (take && op_code == 3'h7 |=>
        skip_next != $past(sel_bit)) else $error("bit skip wrong");
    AST_DUMMY: assert property (take && op_code == 3'h5
        && mem_rdata == 8'h00 |=> dummy_cycle) else $error("skip cycle wrong");
endmodule // sse_exec_props
bind sse_exec sse_exec_props u_props (.*);
`default_nettype wire

/* File: tb/sse_mem_model.sv */
// Purpose: behavioural data memory beside sse_exec
// Assumes: read is combinational, write on the edge after mem_we
// Notes: byte i starts as i so expected values are easy to derive
`timescale 1ns/1ps
`default_nettype none
module sse_mem_model (
    // Read and write sides
    input wire clk, rd_en, we,
    input wire [7:0] rd_addr, wr_addr, wr_data,
    output logic [7:0] rd_data
);
    logic [7:0] ram [0:255];
    initial for (int i = 0; i < 256; i++) ram[i] = i[7:0];
    // Outside a read the lines show junk, never stale data
    assign rd_data = rd_en ? ram[rd_addr] : ~ram[rd_addr];
    always @(posedge clk) begin
        if (we) ram[wr_addr] <= wr_data;
    end
endmodule // sse_mem_model
`default_nettype wire

/* File: tb/sse_exec_tb.sv */
// Purpose: self-checking bench for sse_exec
// Assumes: memory byte i starts as i
// Notes: table rows first, then refusal and mid-run reset
`timescale 1ns/1ps
`default_nettype none
module sse_exec_tb;
    typedef struct packed {
        logic [2:0] op; logic [7:0] arg; logic [2:0] bt;
        logic [7:0] work, mem; logic [3:0] fl; logic skip;
    } sse_row_t;
    logic clk = 1'b0, resetn = 1'b0, op_valid = 1'b0;
    logic [2:0] op_code = 3'h0, op_bit = 3'h0;
    logic [7:0] op_imm = 8'h00, op_addr = 8'h00;
    wire mem_we, busy, skip_next, f_rng, f_nul, f_nib, f_brw, f_sbr, f_cz;
    wire [7:0] mem_addr, mem_wdata, work, mem_rdata;
    int mismatches = 0, n_checks = 0;
    sse_row_t rows [0:12];
    always #2.5 clk = ~clk;
    sse_exec dut (.clk(clk), .resetn(resetn), .op_valid(op_valid),
        .op_code(op_code), .op_imm(op_imm), .op_bit(op_bit),
        .op_addr(op_addr), .mem_rdata(mem_rdata), .mem_we(mem_we),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .working_register(work),
        .signed_range_flag(f_rng), .result_null_flag(f_nul),
        .nibble_carry_flag(f_nib), .borrow_inverse_flag(f_brw),
        .signed_borrow_flag(f_sbr), .chained_zero_flag(f_cz),
        .skip_next(skip_next), .busy(busy));
    sse_mem_model mem (.clk(clk), .rd_en(op_valid), .we(mem_we),
        .rd_addr(op_addr), .wr_addr(mem_addr), .wr_data(mem_wdata),
        .rd_data(mem_rdata));
    task automatic chk8(input logic [7:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // One instruction, then results and the memory byte a cycle later
    task automatic issue(input sse_row_t r);
        @(posedge clk);
        op_valid <= 1'b1;
        {op_code, op_imm, op_addr, op_bit} <= {r.op, r.arg, r.arg, r.bt};
        @(posedge clk);
        op_valid <= 1'b0;
        #1;
        chk8(work, r.work);
        chk8({4'h0, f_rng, f_nib, f_brw, f_nul}, {4'h0, r.fl});
        chk1(f_sbr, ~r.fl[1]);
        chk1(f_cz, r.fl[0]);
        chk1(skip_next, r.skip);
        chk1(busy, r.skip);
        @(posedge clk);
        #1;
        chk8(mem.ram[r.arg], r.mem);
        chk1(busy, 1'b0);
    endtask
    initial begin
        rows = '{'{3'h2, 8'h05, 3'h0, 8'hfb, 8'h05, 4'h0, 1'b0},
            '{3'h2, 8'hfb, 3'h0, 8'h00, 8'hfb, 4'h7, 1'b0},
            '{3'h6, 8'h3c, 3'h0, 8'h3c, 8'h3c, 4'h7, 1'b0},
            '{3'h1, 8'h10, 3'h0, 8'h3c, 8'h2c, 4'h6, 1'b0},
            '{3'h4, 8'h10, 3'h0, 8'hc2, 8'h2c, 4'h6, 1'b0},
            '{3'h3, 8'h10, 3'h0, 8'hc2, 8'hc2, 4'h6, 1'b0},
            '{3'h5, 8'h10, 3'h0, 8'hc2, 8'hc2, 4'h6, 1'b0},
            '{3'h7, 8'h10, 3'h0, 8'hc2, 8'hc2, 4'h6, 1'b1},
            '{3'h7, 8'h10, 3'h7, 8'hc2, 8'hc2, 4'h6, 1'b0},
            '{3'h5, 8'h00, 3'h0, 8'hc2, 8'h00, 4'h6, 1'b1},
            '{3'h6, 8'h00, 3'h0, 8'h00, 8'h00, 4'h6, 1'b1},
            '{3'h6, 8'h80, 3'h0, 8'h80, 8'h80, 4'h6, 1'b0},
            '{3'h2, 8'h01, 3'h0, 8'h7f, 8'h01, 4'ha, 1'b0}};
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        foreach (rows[i]) issue(rows[i]);
        // Subtract held through the dummy cycle is taken only after it
        @(posedge clk);
        op_valid <= 1'b1;
        {op_code, op_addr} <= {3'h5, 8'h00};
        @(posedge clk);
        {op_code, op_imm} <= {3'h2, 8'h01};
        repeat (2) @(posedge clk);
        op_valid <= 1'b0;
        #1;
        chk8(work, 8'h7e);
        // Reset in mid-run clears state
        @(posedge clk);
        resetn <= 1'b0;
        @(posedge clk);
        resetn <= 1'b1;
        #1;
        chk8(work, 8'h00);
        chk8({2'h0, f_rng, f_nul, f_nib, f_brw, f_sbr, f_cz}, 8'h00);
        report_and_stop();
    end
    // Watchdog: the run needs under 100 cycles
    initial begin
        #2000;
        mismatches++;
        report_and_stop();
    end
endmodule // sse_exec_tb
`default_nettype wire
